// ### hw/acc_top.sv
// Control, status and register file of the four-channel 8-bit converter.
// Assumes an APB master on clk and a core that presents its code on
// conv_data while busy; pins and the RC oscillator are asynchronous.
`timescale 1ns/10ps

module acc_top (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic irq_priority_ok,
	input wire logic rc_osc_clk,
	input wire logic power_down,
	input wire logic [7:0] port0_pins,
	input wire logic [7:0] conv_data,
	output acc_pkg::acc_core_ctrl_t core_ctrl,
	output logic [7:0] first_dac_value,
	output logic [7:0] second_dac_value,
	output logic conv_done_irq
);

	// ***************************************************************
	// Declarations
	// ***************************************************************
	logic [9:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
	logic rc_lvl_q, rc_edge, pd_lvl;
	logic [7:0] pin_lvl;
	logic [3:0] div_q, div_d;
	logic mc_tick;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic wr_en, access;
	logic en_q, en_d, second_dac_enable_q, second_dac_enable_d, first_dac_enable_and_result_q, first_dac_enable_and_result_d;
	logic done_q, done_d, busy_q, busy_d, rcsel_q, rcsel_d;
	logic [1:0] chan_q, chan_d;
	logic std_q, std_d, irqen_q, irqen_d, gie_q, gie_d;
	logic valid_q, valid_d;
	logic [7:0] dis_q, dis_d, result_q, result_d, dac1v_q, dac1v_d;
	acc_pkg::acc_state_t st_q, st_d;
	logic [6:0] cnt_q, cnt_d;
	logic start_q, start_d, irq_q, irq_d;
	logic locked;
	logic [7:0] ctl_byte;

	// Register byte of the current write
	function automatic logic [7:0] wr_byte(input logic [31:0] d);
		wr_byte = d[7:0];
	endfunction : wr_byte

	// ***************************************************************
	// Pin synchronisers
	// ***************************************************************
	// Level follows only once stages two and three agree
	always_comb begin
		lvl_d = lvl_q;
		for (int i = 0; i < 10; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				lvl_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= 10'h000;
			s2_q <= 10'h000;
			s3_q <= 10'h000;
			lvl_q <= 10'h000;
			rc_lvl_q <= 1'b0;
		end else begin
			s1_q <= {power_down, rc_osc_clk, port0_pins};
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
			rc_lvl_q <= lvl_q[8];
		end
	end

	assign pin_lvl = lvl_q[7:0];
	assign pd_lvl = lvl_q[9];
	assign rc_edge = lvl_q[8] & ~rc_lvl_q; // One pulse per RC period

	// ***************************************************************
	// Machine cycle divider
	// ***************************************************************
	// Six or twelve clocks per machine cycle
	always_comb begin
		mc_tick = (div_q == ((std_q ? acc_pkg::MC_STD : acc_pkg::MC_FAST)
			- 4'h1));
		div_d = mc_tick ? 4'h0 : div_q + 4'h1;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_q <= 4'h0;
		end else begin
			div_q <= div_d;
		end
	end

	// ***************************************************************
	// APB slave
	// ***************************************************************
	assign access = psel & penable;
	assign wr_en = access & pready_q & pwrite & pstrb[0];
	assign locked = busy_q | done_q;
	assign ctl_byte = {en_q, second_dac_enable_q, first_dac_enable_and_result_q, done_q, busy_q, rcsel_q,
		chan_q};

	// One wait state; read data sampled in the first access cycle
	always_comb begin
		pready_d = access & ~pready_q;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		if (access & ~pready_q) begin
			prdata_d = 32'h0000_0000;
			if (paddr == acc_pkg::OFS_CONTROL) begin
				prdata_d[7:0] = ctl_byte;
			end else if (paddr == acc_pkg::OFS_DIG_DIS) begin
				prdata_d[7:0] = dis_q;
			end else if (paddr == acc_pkg::OFS_RESULT) begin
				prdata_d[7:0] = result_q;
			end else if (paddr == acc_pkg::OFS_SECOND_DAC_ENABLE) begin
				prdata_d[7:0] = dac1v_q;
			end else if (paddr == acc_pkg::OFS_CONFIG) begin
				prdata_d[3:0] = {valid_q, gie_q, irqen_q, std_q};
			end else if (paddr == acc_pkg::OFS_PORT0) begin
				prdata_d[7:0] = pin_lvl & ~dis_q;
			end else begin
				pslverr_d = 1'b1;
			end
		end else if (access) begin
			pslverr_d = pslverr_q;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;

	// ***************************************************************
	// Control register, sequencer and result
	// ***************************************************************
	always_comb begin
		en_d = en_q;
		second_dac_enable_d = second_dac_enable_q;
		first_dac_enable_and_result_d = first_dac_enable_and_result_q;
		done_d = done_q;
		busy_d = busy_q;
		rcsel_d = rcsel_q;
		chan_d = chan_q;
		std_d = std_q;
		irqen_d = irqen_q;
		gie_d = gie_q;
		valid_d = valid_q;
		dis_d = dis_q;
		result_d = result_q;
		dac1v_d = dac1v_q;
		st_d = st_q;
		cnt_d = cnt_q;
		start_d = 1'b0;
		// Software writes
		if (wr_en && paddr == acc_pkg::OFS_CONTROL) begin
			if (pwdata[acc_pkg::B_ENABLE] || !locked) begin
				en_d = pwdata[acc_pkg::B_ENABLE];
			end
			second_dac_enable_d = pwdata[acc_pkg::B_SECOND_DAC_ENABLE];
			done_d = done_q & pwdata[acc_pkg::B_DONE];
			if (!locked) begin
				first_dac_enable_and_result_d = pwdata[acc_pkg::B_FIRST_DAC_ENABLE_AND_RESULT];
				rcsel_d = pwdata[acc_pkg::B_CLKSEL];
				chan_d = pwdata[acc_pkg::B_CHAN_HI:acc_pkg::B_CHAN_LO];
				if (pwdata[acc_pkg::B_START] && en_d) begin
					busy_d = 1'b1;
					start_d = 1'b1;
					cnt_d = 7'h00;
					st_d = pwdata[acc_pkg::B_CLKSEL] ? acc_pkg::ST_SYNC
						: acc_pkg::ST_CONV;
				end
			end
			// A zero start bit never stops a running conversion
		end else if (wr_en && paddr == acc_pkg::OFS_DIG_DIS) begin
			dis_d = wr_byte(pwdata);
		end else if (wr_en && paddr == acc_pkg::OFS_RESULT && !busy_q) begin
			result_d = wr_byte(pwdata);
		end else if (wr_en && paddr == acc_pkg::OFS_SECOND_DAC_ENABLE) begin
			dac1v_d = wr_byte(pwdata);
		end else if (wr_en && paddr == acc_pkg::OFS_CONFIG) begin
			std_d = pwdata[acc_pkg::C_STD_TIMING];
			irqen_d = pwdata[acc_pkg::C_IRQ_EN];
			gie_d = pwdata[acc_pkg::C_GLOBAL_IE];
		end
		// Conversion sequencer; its done set wins over a software clear
		case (st_q)
			acc_pkg::ST_SYNC: begin
				if (pd_lvl && !rcsel_q) begin
					st_d = acc_pkg::ST_IDLE;
				end else if (cnt_q >= acc_pkg::SYNC_MC && rc_edge) begin
					cnt_d = 7'h00;
					st_d = acc_pkg::ST_CONV;
				end else if (mc_tick && cnt_q < acc_pkg::SYNC_MC) begin
					cnt_d = cnt_q + 7'h01;
				end
			end
			acc_pkg::ST_CONV: begin
				if (pd_lvl && !rcsel_q) begin
					busy_d = 1'b0;
					valid_d = 1'b0;
					st_d = acc_pkg::ST_IDLE;
				end else if ((rcsel_q ? rc_edge : mc_tick)) begin
					cnt_d = cnt_q + 7'h01;
					if (cnt_q + 7'h01 ==
						(rcsel_q ? acc_pkg::RC_CONV : acc_pkg::CONV_MC)) begin
						done_d = 1'b1;
						result_d = conv_data;
						valid_d = 1'b1;
						st_d = acc_pkg::ST_OVERLAP;
					end
				end
			end
			acc_pkg::ST_OVERLAP: begin
				if (mc_tick) begin
					busy_d = 1'b0;
					st_d = acc_pkg::ST_IDLE;
				end
			end
			default: begin
				busy_d = busy_d;
			end
		endcase
		if (st_q == acc_pkg::ST_SYNC && pd_lvl && !rcsel_q) begin
			busy_d = 1'b0;
			valid_d = 1'b0;
		end
	end

	// Interrupt request needs both enables and a won priority
	assign irq_d = done_q & irqen_q & gie_q & irq_priority_ok;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			en_q <= 1'b0;
			second_dac_enable_q <= 1'b0;
			first_dac_enable_and_result_q <= 1'b0;
			done_q <= 1'b0;
			busy_q <= 1'b0;
			rcsel_q <= 1'b0;
			chan_q <= 2'h0;
			std_q <= 1'b0;
			irqen_q <= 1'b0;
			gie_q <= 1'b0;
			valid_q <= 1'b0;
			dis_q <= acc_pkg::RST_BYTE;
			result_q <= acc_pkg::RST_BYTE;
			dac1v_q <= acc_pkg::RST_BYTE;
			st_q <= acc_pkg::ST_IDLE;
			cnt_q <= 7'h00;
			start_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			en_q <= en_d;
			second_dac_enable_q <= second_dac_enable_d;
			first_dac_enable_and_result_q <= first_dac_enable_and_result_d;
			done_q <= done_d;
			busy_q <= busy_d;
			rcsel_q <= rcsel_d;
			chan_q <= chan_d;
			std_q <= std_d;
			irqen_q <= irqen_d;
			gie_q <= gie_d;
			valid_q <= valid_d;
			dis_q <= dis_d;
			result_q <= result_d;
			dac1v_q <= dac1v_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			start_q <= start_d;
			irq_q <= irq_d;
		end
	end

	// ***************************************************************
	// Outputs
	// ***************************************************************
	assign core_ctrl = '{converter_enable: en_q, second_dac_enable: second_dac_enable_q,
		first_dac_enable: first_dac_enable_and_result_q, converter_clock_select: rcsel_q,
		channel: chan_q, start: start_q};
	assign first_dac_value = result_q; // Shared result and DAC data
	assign second_dac_value = dac1v_q;
	assign conv_done_irq = irq_q;

endmodule : acc_top

// ### hw/acc_pkg.sv
// Constants, types and register map of the converter control block.
// Assumes an APB master with 32-bit data and a 125 MHz clock.
//
// Summary of operation
// - Machine cycle is six clocks, or twelve with standard timing.
// - A set disable bit makes its port 0 pin read as zero.
// - Channel bits are writable only while busy and done are both zero.
// - Writing start begins a conversion; busy clears itself when done.
// - Done requests an interrupt if both enables set and priority won.
// - The 8-bit result lands in the shared result register, held.
// - Starts are ignored while busy or done; software clears done.
// - A start write may load the channel; a done clear may not.
// - Result is the input scaled by 256 over the supply span, rounded.
// - Control register is byte-wide, reset zero, in the listed bit order.
// - Converter enable cannot be cleared while busy or done.
// - Bit 6 enables the second DAC output.
// - Bit 5 enables the first DAC, writable only while idle.
// - Bit 2 picks CPU or RC clock, writable only while idle.
// - Done and busy both read one for one machine cycle at completion on CPU clock, for up to one on RC clock.
// - Channel 00 routes analog input zero, 01 analog input one.
// - On CPU clock a conversion ends 31 machine cycles after start.
// - On RC clock: sync machine cycles plus 108 to 109 RC periods.
// - Power-down on CPU clock aborts; result then flagged invalid.

package acc_pkg;

	// ***************************************************************
	// Register map (byte addresses)
	// ***************************************************************
	localparam logic [11:0] OFS_CONTROL = 12'h0C0;
	localparam logic [11:0] OFS_DIG_DIS = 12'h0C4;
	localparam logic [11:0] OFS_RESULT = 12'h0C8;
	localparam logic [11:0] OFS_SECOND_DAC_ENABLE = 12'h0CC;
	localparam logic [11:0] OFS_CONFIG = 12'h0D0;
	localparam logic [11:0] OFS_PORT0 = 12'h0D4;

	// ***************************************************************
	// Control register bit positions
	// ***************************************************************
	localparam int B_ENABLE = 7;
	localparam int B_SECOND_DAC_ENABLE = 6;
	localparam int B_FIRST_DAC_ENABLE_AND_RESULT = 5;
	localparam int B_DONE = 4;
	localparam int B_START = 3;
	localparam int B_CLKSEL = 2;
	localparam int B_CHAN_HI = 1;
	localparam int B_CHAN_LO = 0;

	// Config register bit positions
	localparam int C_STD_TIMING = 0;
	localparam int C_IRQ_EN = 1;
	localparam int C_GLOBAL_IE = 2;
	localparam int C_RES_VALID = 3;

	// Reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// ***************************************************************
	// Timing counts
	// ***************************************************************
	localparam logic [3:0] MC_FAST = 4'h6;
	localparam logic [3:0] MC_STD = 4'hC;
	localparam logic [6:0] CONV_MC = 7'h1F;
	localparam logic [6:0] SYNC_MC = 7'h03;
	localparam logic [6:0] RC_CONV = 7'h6C;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SYNC = 2'b01,
		ST_CONV = 2'b10,
		ST_OVERLAP = 2'b11
	} acc_state_t;

	// Controls toward the multiplexer and converter core
	typedef struct packed {
		logic converter_enable;
		logic second_dac_enable;
		logic first_dac_enable;
		logic converter_clock_select;
		logic [1:0] channel;
		logic start;
	} acc_core_ctrl_t;

endpackage : acc_pkg

// ### verification/acc_chk.sv
// Concurrent checks on the ports of the converter control block.
// Assumes one clock domain, nrst asynchronous and active low.
`timescale 1ns/10ps

module acc_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq_priority_ok,
	input wire acc_pkg::acc_core_ctrl_t core_ctrl,
	input wire logic [7:0] first_dac_value,
	input wire logic conv_done_irq
);
	logic [8:0] gap_q, gap_d;
	wire busy = gap_q < 9'h0AA;

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// Cycles since the last start pulse, saturating
	always_comb begin
		gap_d = gap_q;
		if (core_ctrl.start)
			gap_d = 9'h000;
		else if (gap_q != 9'h1FF)
			gap_d = gap_q + 9'h001;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			gap_q <= 9'h1FF;
		else
			gap_q <= gap_d;
	end

	property p_ready;
		pready |-> $past(psel && penable) ##1 !pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("stray or long pready");
	property p_start;
		core_ctrl.start |-> core_ctrl.converter_enable ##1 !core_ctrl.start;
	endproperty
	a_start: assert property (p_start)
		else $error("bad start pulse");
	property p_gap;
		core_ctrl.start |-> gap_q >= 9'h0BA;
	endproperty
	a_gap: assert property (p_gap)
		else $error("start accepted while busy");
	property p_chan;
		busy |-> $stable(core_ctrl.channel);
	endproperty
	a_chan: assert property (p_chan)
		else $error("channel moved in conversion");
	property p_en;
		busy |-> $stable(core_ctrl.converter_enable);
	endproperty
	a_en: assert property (p_en)
		else $error("enable moved in conversion");
	property p_dac_clk;
		busy |-> $stable({core_ctrl.first_dac_enable,
			core_ctrl.converter_clock_select});
	endproperty
	a_dac_clk: assert property (p_dac_clk)
		else $error("locked bit moved in conversion");
	property p_res;
		busy |-> $stable(first_dac_value);
	endproperty
	a_res: assert property (p_res)
		else $error("result moved in conversion");
	property p_time;
		$rose(conv_done_irq) && gap_q < 9'h190 &&
			!core_ctrl.converter_clock_select |->
			gap_q inside {[9'h0B2:9'h17C]};
	endproperty
	a_time: assert property (p_time)
		else $error("conversion length wrong");
	property p_prio;
		conv_done_irq |-> $past(irq_priority_ok);
	endproperty
	a_prio: assert property (p_prio)
		else $error("irq without priority");

	c_start: cover property (core_ctrl.start);
	c_err: cover property (pslverr);
	c_irq: cover property ($rose(conv_done_irq));
endmodule : acc_chk

// ### verification/acc_core_model.sv
// Multiplexer and converter core beside the control block.
// Assumes core_ctrl from the design; the RC oscillator runs free.
`timescale 1ns/10ps

module acc_core_model (
	input wire logic clk,
	input wire acc_pkg::acc_core_ctrl_t core_ctrl,
	output logic [7:0] conv_data,
	output logic rc_osc_clk
);
	logic [7:0] junk_q = 8'h5A;

	// Oscillator, 40 ns period, edges kept off the clock edges
	initial begin
		rc_osc_clk = 1'b0;
		#3;
		forever #20 rc_osc_clk = ~rc_osc_clk;
	end
	// Changing pattern while the core is off
	always @(posedge clk)
		junk_q <= junk_q ^ 8'hA5;
	// Fixed input voltage per routed channel
	assign conv_data = core_ctrl.converter_enable ?
		8'h21 + 8'h46 * {6'h00, core_ctrl.channel} : junk_q;
endmodule : acc_core_model

// ### verification/acc_tb_top.sv
// Self-checking bench of the converter control block over APB.
// Assumes the package, acc_top, the core model and the checker.
`timescale 1ns/10ps

module acc_tb_top;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, e;
	logic irq_priority_ok, rc_osc_clk, power_down, conv_done_irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [7:0] port0_pins, conv_data, dis, ctl, first_dac_value;
	logic [7:0] codes [4] = '{8'h21, 8'h67, 8'hAD, 8'hF3};
	logic [3:0] pstrb;
	acc_pkg::acc_core_ctrl_t core_ctrl;
	int miscompares, n_tests, ch, n;

	acc_top dut_u(.clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .irq_priority_ok, .rc_osc_clk,
		.power_down, .port0_pins, .conv_data, .core_ctrl, .first_dac_value,
		.second_dac_value(), .conv_done_irq);
	acc_core_model core_u(.clk, .core_ctrl, .conv_data, .rc_osc_clk);

	// Clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task chk(input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x) begin
			miscompares++;
			$display("mismatch at %0t: got %h exp %h", $time, s, x);
		end
	endtask : chk

	// One APB transfer, held until pready
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'($urandom), d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		n = 0;
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n >= 50)
			miscompares++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task end_of_test;
		$display("tests %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	// Watchdog
	initial begin
		#160000;
		miscompares++;
		end_of_test;
	end

	// Main sequence
	initial begin
		{psel, penable, pwrite, power_down} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		irq_priority_ok = 1'b1;
		port0_pins = 8'h00;
		nrst = 1'b0;
		void'($urandom(59354));
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		apb(0, acc_pkg::OFS_CONTROL, 8'h00);
		chk(r, 32'h0);
		apb(0, 12'h0F0, 8'h00);
		chk(e, 32'h1);
		port0_pins <= 8'($urandom);
		dis = 8'($urandom);
		apb(1, acc_pkg::OFS_DIG_DIS, dis);
		apb(0, acc_pkg::OFS_PORT0, 8'h00);
		chk(r, {24'h0, port0_pins & ~dis});
		apb(1, acc_pkg::OFS_CONFIG, 8'h06);
		apb(1, acc_pkg::OFS_DIG_DIS, 8'h78);
		apb(0, acc_pkg::OFS_PORT0, 8'h00);
		chk(r, {24'h0, port0_pins & 8'h87});
		apb(1, acc_pkg::OFS_CONTROL, 8'h80);
		repeat (1250) @(posedge clk);
		for (ch = 0; ch < 4; ch++) begin
			if (ch == 3)
				apb(1, acc_pkg::OFS_CONFIG, 8'h07);
			irq_priority_ok <= (ch != 2);
			ctl = 8'h88 | 8'(ch);
			apb(1, acc_pkg::OFS_CONTROL, ctl);
			apb(1, acc_pkg::OFS_CONTROL, 8'h74);
			ctl = ctl | 8'h40;
			apb(0, acc_pkg::OFS_CONTROL, 8'h00);
			chk(r, {24'h0, ctl});
			repeat (600) @(posedge clk);
			chk(conv_done_irq, 32'(ch != 2));
			irq_priority_ok <= 1'b1;
			repeat (2) @(posedge clk);
			chk(conv_done_irq, 32'h1);
			ctl = (ctl & 8'hF7) | 8'h10;
			apb(0, acc_pkg::OFS_CONTROL, 8'h00);
			chk(r, {24'h0, ctl});
			apb(0, acc_pkg::OFS_RESULT, 8'h00);
			chk(r, {24'h0, codes[ch]});
			apb(1, acc_pkg::OFS_CONTROL, ctl | 8'h08);
			apb(0, acc_pkg::OFS_CONTROL, 8'h00);
			chk(r, {24'h0, ctl});
			apb(1, acc_pkg::OFS_CONTROL, (ctl & 8'hEC) | 8'(~ch & 3));
			apb(0, acc_pkg::OFS_CONTROL, 8'h00);
			chk(r, {24'h0, ctl & 8'hEF});
			apb(1, acc_pkg::OFS_CONTROL, 8'h80);
		end
		apb(1, acc_pkg::OFS_CONFIG, 8'h06);
		apb(1, acc_pkg::OFS_CONTROL, 8'h84);
		apb(1, acc_pkg::OFS_CONTROL, 8'h8D);
		repeat (300) @(posedge clk);
		apb(0, acc_pkg::OFS_CONTROL, 8'h00);
		chk(r, 32'h8D);
		repeat (500) @(posedge clk);
		apb(0, acc_pkg::OFS_RESULT, 8'h00);
		chk(r, {24'h0, codes[1]});
		apb(1, acc_pkg::OFS_CONTROL, 8'h85);
		apb(1, acc_pkg::OFS_CONTROL, 8'h80);
		apb(1, acc_pkg::OFS_CONTROL, 8'h88);
		repeat (20) @(posedge clk);
		power_down <= 1'b1;
		repeat (10) @(posedge clk);
		apb(0, acc_pkg::OFS_CONTROL, 8'h00);
		chk(r, 32'h80);
		apb(0, acc_pkg::OFS_CONFIG, 8'h00);
		chk(r[3], 32'h0);
		power_down <= 1'b0;
		repeat (300) @(posedge clk);
		chk(conv_done_irq, 32'h0);
		end_of_test;
	end
endmodule : acc_tb_top

bind acc_top acc_chk u_chk(.clk, .nrst, .psel, .penable, .pready,
	.pslverr, .irq_priority_ok, .core_ctrl, .first_dac_value,
	.conv_done_irq);
